// ### bench/scbc_host_model.sv
// host side model: speed command strobes and the brake pin
`timescale 1ns/10ps
`default_nettype none
`include "scbc_map.svh"
module scbc_host_model (
  // clock
  input  wire logic                   clk,
  // lines into the block
  output logic      [`SCBC_CMD_W-1:0] speed_command,
  output logic                        speed_valid,
  output logic                        brake_pin
);
  // idle levels at time zero
  initial
  begin
    speed_command = 10'h000;
    speed_valid   = 1'b0;
    brake_pin     = 1'b0;
  end

  // one strobe per command; last releases the bus, which then shows inverted data
  // so that nothing can lean on a stale command
  task automatic send(input logic [`SCBC_CMD_W-1:0] x, input bit last);
    @(negedge clk);
    speed_command <= x;
    speed_valid   <= 1'b1;
    if (last)
    begin
      @(negedge clk);
      speed_valid   <= 1'b0;
      speed_command <= ~x;
    end
  endtask : send

  // pin level changes off the sampling edge
  task automatic set_brake(input logic level);
    @(negedge clk);
    brake_pin <= level;
  endtask : set_brake
endmodule : scbc_host_model
`default_nettype wire

// ### bench/scbc_top_tb.sv
// self-checking bench of the speed curve and brake control block
`timescale 1ns/10ps
`default_nettype none
module scbc_top_tb;
  // clock, reset and host lines
  logic            clk;
  logic            rst;
  wire logic [9:0] spd_cmd;
  wire logic       spd_valid;
  wire logic       brk_pin;
  // settings and fault sources
  logic            pol, fss, open_mode, clamp_open, keep_run, zero_full, dir_duty;
  logic [1:0]      btype;
  logic [7:0]      start_th, clamp_th, change;
  logic [6:0]      stop_th;
  logic [3:0]      hys;
  logic [11:0]     start_spd;
  logic [13:0]     slope, slope2;
  logic            uv, oc, ts, lock;
  // results
  logic [17:0]     target;
  logic            tvalid, open_drive, out_en, dir_fwd, rising, fault, lock_en;
  logic [1:0]      brake_act;
  int              fail_count;
  int              samples_checked;

  scbc_host_model host (.clk(clk), .speed_command(spd_cmd), .speed_valid(spd_valid),
    .brake_pin(brk_pin));

  scbc_top dut (.CORE_CLK(clk), .RST(rst), .SPEED_COMMAND(spd_cmd), .SPEED_VALID(spd_valid),
    .BRAKE_PIN(brk_pin), .BRAKE_POLARITY(pol), .BRAKE_TYPE(btype), .FAULT_SOURCE_SELECT(fss),
    .OPEN_LOOP_MODE(open_mode), .CLAMP_OPEN_LOOP(clamp_open), .KEEP_RUNNING(keep_run),
    .ZERO_COMMAND_FULL(zero_full), .DIRECTION_BY_DUTY(dir_duty),
    .STARTUP_THRESHOLD(start_th), .STOP_THRESHOLD(stop_th), .CLAMP_THRESHOLD(clamp_th),
    .CLAMP_HYSTERESIS(hys), .STARTUP_SPEED(start_spd), .SPEED_SLOPE(slope),
    .SECOND_SLOPE(slope2), .CHANGE_POINT(change), .CHARGE_PUMP_UV(uv),
    .OVERCURRENT_SHUTDOWN(oc), .THERMAL_SHUTDOWN(ts), .MOTOR_LOCK(lock), .TARGET(target),
    .TARGET_VALID(tvalid), .OPEN_DRIVE(open_drive), .OUT_ENABLE(out_en),
    .DIR_FORWARD(dir_fwd), .RISING(rising), .BRAKE_ACTION(brake_act), .FAULT(fault),
    .FAULT_LOCK_ENABLE(lock_en));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // one comparison, counted; four-state equality so unknowns never match
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // verdict, the one place the run ends
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // reset held 8 cycles, reset values checked on the last held cycle
  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (8) @(negedge clk);
    check("target", target, 18'h00000);
    check("valid", tvalid, 18'h00000);
    check("open", open_drive, 18'h00000);
    check("enable", out_en, 18'h00000);
    check("forward", dir_fwd, 18'h00001);
    check("rising", rising, 18'h00000);
    check("brake", brake_act, 18'h00000);
    check("fault", fault, 18'h00000);
    check("lock enable", lock_en, 18'h00000);
    rst = 1'b0;
  endtask : do_reset

  // one command, fixed two-edge answer, then target and enable judged
  task automatic expect_cmd(input logic [9:0] x, input logic [17:0] t, input logic od);
    int n;
    // the taking edge has already passed when send returns
    n = 1;
    host.send(x, 1'b1);
    do
    begin
      @(negedge clk);
      n++;
    end
    while (tvalid !== 1'b1 && n < 6);
    check("latency", 18'(n), 18'h00002);
    check("target", target, t);
    check("open", open_drive, 18'(od));
    check("enable", out_en, 18'(t != 18'h00000));
  endtask : expect_cmd

  // pin versus polarity versus type, every code
  task automatic test_brake();
    for (int p = 0; p < 2; p++)
      for (int pin = 0; pin < 2; pin++)
        for (int ty = 0; ty < 4; ty++)
        begin
          host.set_brake(pin[0]);
          pol = p[0];
          btype = ty[1:0];
          repeat (4) @(negedge clk);
          check("brake", brake_act, (pin[0] ^ p[0]) ? 18'(ty[1:0]) : 18'h00000);
        end
    $display("brake test done");
  endtask : test_brake

  // power-on brake state decides whether lock reaches the fault output
  task automatic test_fault(input logic [1:0] ty, input logic exp_lock);
    host.set_brake(1'b1);
    pol = 1'b0;
    btype = ty;
    fss = 1'b1;
    do_reset();
    repeat (6) @(negedge clk);
    check("lock enable", lock_en, 18'(exp_lock));
    lock = 1'b1;
    repeat (2) @(negedge clk);
    check("fault lock", fault, 18'(exp_lock));
    lock = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      {uv, oc, ts} = 3'b100 >> i;
      repeat (2) @(negedge clk);
      check("fault source", fault, 18'h00001);
    end
    {uv, oc, ts} = 3'b000;
    $display("fault test done");
  endtask : test_fault

  // closed loop: start 100, stop 80, clamp 300, 10 rpm per step
  task automatic test_closed();
    expect_cmd(10'h0C8, 18'h007D0, 1'b0);
    check("rising", rising, 18'h00001);
    expect_cmd(10'h190, 18'h00BB8, 1'b0);
    expect_cmd(10'h05A, 18'h003E8, 1'b0);
    expect_cmd(10'h050, 18'h00000, 1'b0);
    expect_cmd(10'h05A, 18'h00000, 1'b0);
    expect_cmd(10'h065, 18'h003F2, 1'b0);
    expect_cmd(10'h000, 18'h00000, 1'b0);
    $display("closed test done");
  endtask : test_closed

  // clamp bypass with a band of 8
  task automatic test_bypass();
    clamp_open = 1'b1;
    expect_cmd(10'h190, 18'h00190, 1'b1);
    expect_cmd(10'h3FF, 18'h00200, 1'b1);
    expect_cmd(10'h127, 18'h00127, 1'b1);
    expect_cmd(10'h124, 18'h00B68, 1'b0);
    $display("bypass test done");
  endtask : test_bypass

  // zero command and keep-running options
  task automatic test_zero();
    clamp_open = 1'b0;
    zero_full = 1'b1;
    expect_cmd(10'h000, 18'h00BB8, 1'b0);
    clamp_open = 1'b1;
    expect_cmd(10'h000, 18'h00200, 1'b1);
    zero_full = 1'b0;
    keep_run = 1'b1;
    expect_cmd(10'h032, 18'h003E8, 1'b0);
    zero_full = 1'b1;
    expect_cmd(10'h046, 18'h00200, 1'b1);
    expect_cmd(10'h05A, 18'h003E8, 1'b0);
    {clamp_open, zero_full, keep_run} = 3'b000;
    $display("zero test done");
  endtask : test_zero

  // change point at 200 with 20 rpm per step beyond it
  task automatic test_change();
    change = 8'h64;
    expect_cmd(10'h0FA, 18'h00BB8, 1'b0);
    expect_cmd(10'h096, 18'h005DC, 1'b0);
    change = 8'h00;
    expect_cmd(10'h0FA, 18'h009C4, 1'b0);
    $display("change test done");
  endtask : test_change

  // open loop: startup duty 100, two duty steps per command step
  task automatic test_open();
    open_mode = 1'b1;
    start_spd = 12'h640;
    slope = 14'h0800;
    expect_cmd(10'h096, 18'h000C8, 1'b1);
    expect_cmd(10'h190, 18'h001F4, 1'b1);
    expect_cmd(10'h032, 18'h00000, 1'b1);
    open_mode = 1'b0;
    start_spd = 12'h3E8;
    slope = 14'h0280;
    $display("open test done");
  endtask : test_open

  // direction by duty around half scale, then back-to-back commands
  task automatic test_dir_b2b();
    dir_duty = 1'b1;
    expect_cmd(10'h0FF, 18'h009F6, 1'b0);
    check("forward", dir_fwd, 18'h00000);
    expect_cmd(10'h100, 18'h00A00, 1'b0);
    check("forward", dir_fwd, 18'h00001);
    host.send(10'h0C8, 1'b0);
    host.send(10'h0CA, 1'b1);
    check("b2b valid", tvalid, 18'h00001);
    check("b2b target", target, 18'h007D0);
    @(negedge clk);
    check("b2b valid", tvalid, 18'h00001);
    check("b2b target", target, 18'h007E4);
    host.send(10'h190, 1'b0);
    host.send(10'h1F4, 1'b1);
    check("clamp target", target, 18'h00BB8);
    @(negedge clk);
    check("clamp valid", tvalid, 18'h00001);
    check("clamp target", target, 18'h00BB8);
    $display("direction test done");
  endtask : test_dir_b2b

  // watchdog sized well beyond the few hundred cycles the tests take
  initial
  begin
    #200000;
    fail_count++;
    summarize();
  end

  // main sequence
  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    {pol, fss, open_mode, clamp_open, keep_run, zero_full, dir_duty} = 7'h00;
    btype = 2'h0;
    {uv, oc, ts, lock} = 4'h0;
    start_th = 8'h64;
    stop_th = 7'h28;
    clamp_th = 8'h2B;
    hys = 4'h3;
    start_spd = 12'h3E8;
    slope = 14'h0280;
    slope2 = 14'h0500;
    change = 8'h00;
    test_fault(2'h2, 1'b1);
    test_fault(2'h1, 1'b0);
    test_brake();
    test_closed();
    test_bypass();
    test_zero();
    test_change();
    test_open();
    test_dir_b2b();
    summarize();
  end
endmodule : scbc_top_tb
`default_nettype wire

// ### hdl/scbc_brake_ctrl.sv
// brake pin decode and power-on fault source selection
`timescale 1ns/10ps
`default_nettype none
`include "scbc_map.svh"
module scbc_brake_ctrl (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // pin and settings
  input  wire logic       brake_pin,
  input  wire logic       brake_polarity,
  input  wire logic [1:0] brake_type,
  input  wire logic       fault_source_select,
  // results
  output logic      [1:0] brake_action,
  output logic            lock_enable
);
  logic       pin_meta;
  logic       pin_sync;
  logic [1:0] por_cnt;
  wire        brake_req;
  wire  [1:0] next_action;
  scbc_pkg::scbc_por_t por_state;
  // pin from outside the clock domain: two flops before use
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= brake_pin;
      pin_sync <= pin_meta;
    end
  end
  // polarity low means active high pin
  assign brake_req   = pin_sync ^ brake_polarity;
  assign next_action = brake_req ? brake_type : 2'h0;
  always_ff @(posedge clk)
  begin
    if (rst)
      brake_action <= 2'h0;
    else
      brake_action <= next_action;
  end
  // wait for the synchroniser to fill before judging the power-on state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      por_cnt     <= 2'h0;
      por_state   <= scbc_pkg::SCBC_POR_WAIT;
      lock_enable <= 1'b0;
    end
    else
    begin
      unique case (por_state)
        scbc_pkg::SCBC_POR_WAIT:
        begin
          por_cnt <= por_cnt + 2'h1;
          if (por_cnt == `SCBC_POR_SETTLE)
          begin
            por_state   <= scbc_pkg::SCBC_POR_DONE;
            lock_enable <= fault_source_select
                           && (next_action == scbc_pkg::SCBC_BRAKE_REVERSE);
          end
        end
        scbc_pkg::SCBC_POR_DONE:
          por_cnt <= por_cnt;
      endcase
    end
  end
  AST_BRAKE_OFF: assert property (@(posedge clk) disable iff (rst)
    !$past(brake_req) |-> brake_action == 2'h0)
    else $error("brake applied without request");
  AST_LOCK_FROZEN: assert property (@(posedge clk) disable iff (rst)
    por_state == scbc_pkg::SCBC_POR_DONE && $past(por_state) == scbc_pkg::SCBC_POR_DONE
    |-> $stable(lock_enable))
    else $error("lock selection changed after power-on");
endmodule : scbc_brake_ctrl
`default_nettype wire

// ### hdl/scbc_map.svh
// constants and offsets of the speed curve and brake control block
// What this block does
// - speed command spans 0 to 512, ten bits
// - brake requested only when pin differs from polarity
// - brake type field selects none/short/reverse/mild
// - reverse brake at power-on plus select adds lock
// - output enabled above startup threshold
// - output disabled at twice stop setting
// - closed loop holds speed above clamp threshold
// - clamp open-loop bypass with hysteresis band
// - startup speed used directly in rpm
// - linear rise using slope over sixty-four, over 1024 in open loop
// - zero region; zero command gives full option
// - stop-to-startup band follows command direction
// - keep-running holds startup speed, full option
// - change point at twice setting, zero disables
// - second slope beyond change point
// - direction by duty: half or more forward
// - open loop duty uses same thresholds, clamps
// - open loop duty follows command when bypassing
// - open loop startup duty from upper eight bits
`ifndef SCBC_MAP_SVH
`define SCBC_MAP_SVH
`define SCBC_CMD_W        10
`define SCBC_CMD_FULL     10'h200
`define SCBC_CMD_HALF     10'h100
`define SCBC_CLAMP_BASE   10'h101
`define SCBC_OUT_W        18
`define SCBC_SHIFT_SPEED  4'h6
`define SCBC_SHIFT_DUTY   4'hA
`define SCBC_DUTY_FULL    18'h00200
`define SCBC_POR_SETTLE   2'h3
`endif

// ### hdl/scbc_pkg.sv
// types shared by the speed curve and brake control block
`default_nettype none
package scbc_pkg;
  typedef enum logic [1:0] {
    SCBC_BRAKE_NONE,
    SCBC_BRAKE_SHORT,
    SCBC_BRAKE_REVERSE,
    SCBC_BRAKE_MILD
  } scbc_brake_t;
  typedef enum {SCBC_POR_WAIT, SCBC_POR_DONE} scbc_por_t;
endpackage : scbc_pkg
`default_nettype wire

// ### hdl/scbc_slope_seg.sv
// one linear segment of the speed curve: base plus scaled slope
`timescale 1ns/10ps
`default_nettype none
`include "scbc_map.svh"
module scbc_slope_seg (
  // segment start and slope
  input  wire logic [`SCBC_OUT_W-1:0] base,
  input  wire logic [13:0]            slope,
  input  wire logic [3:0]             shift,
  // evaluation point and segment origin
  input  wire logic [`SCBC_CMD_W-1:0] x,
  input  wire logic [`SCBC_CMD_W-1:0] x0,
  // result
  output logic      [`SCBC_OUT_W-1:0] value
);
  logic [`SCBC_CMD_W-1:0] span;
  logic [23:0]            prod;
  logic [23:0]            scaled;
  // below the origin the segment contributes nothing
  assign span   = (x > x0) ? x - x0 : '0;
  assign prod   = slope * span;
  assign scaled = prod >> shift;
  assign value  = base + scaled[`SCBC_OUT_W-1:0];
endmodule : scbc_slope_seg
`default_nettype wire

// ### hdl/scbc_top.sv
// speed command to target curve, with brake decode and fault gating
`timescale 1ns/10ps
`default_nettype none
`include "scbc_map.svh"
module scbc_top (
  // clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST,
  // speed command from the command decoder
  input  wire logic [`SCBC_CMD_W-1:0] SPEED_COMMAND,
  input  wire logic                   SPEED_VALID,
  // brake pin and brake settings
  input  wire logic                   BRAKE_PIN,
  input  wire logic                   BRAKE_POLARITY,
  input  wire logic [1:0]             BRAKE_TYPE,
  input  wire logic                   FAULT_SOURCE_SELECT,
  // curve mode settings
  input  wire logic                   OPEN_LOOP_MODE,
  input  wire logic                   CLAMP_OPEN_LOOP,
  input  wire logic                   KEEP_RUNNING,
  input  wire logic                   ZERO_COMMAND_FULL,
  input  wire logic                   DIRECTION_BY_DUTY,
  // curve thresholds and slopes
  input  wire logic [7:0]             STARTUP_THRESHOLD,
  input  wire logic [6:0]             STOP_THRESHOLD,
  input  wire logic [7:0]             CLAMP_THRESHOLD,
  input  wire logic [3:0]             CLAMP_HYSTERESIS,
  input  wire logic [11:0]            STARTUP_SPEED,
  input  wire logic [13:0]            SPEED_SLOPE,
  input  wire logic [13:0]            SECOND_SLOPE,
  input  wire logic [7:0]             CHANGE_POINT,
  // fault sources
  input  wire logic                   CHARGE_PUMP_UV,
  input  wire logic                   OVERCURRENT_SHUTDOWN,
  input  wire logic                   THERMAL_SHUTDOWN,
  input  wire logic                   MOTOR_LOCK,
  // curve results
  output logic      [`SCBC_OUT_W-1:0] TARGET,
  output logic                        TARGET_VALID,
  output logic                        OPEN_DRIVE,
  output logic                        OUT_ENABLE,
  output logic                        DIR_FORWARD,
  output logic                        RISING,
  // brake and fault results
  output logic      [1:0]             BRAKE_ACTION,
  output logic                        FAULT,
  output logic                        FAULT_LOCK_ENABLE
);
  logic [`SCBC_CMD_W-1:0] cmd;
  logic                   upd;
  logic                   run;
  logic                   bypass;
  logic [`SCBC_CMD_W-1:0] prev_cmd;
  wire  [`SCBC_CMD_W-1:0] start_pt;
  wire  [`SCBC_CMD_W-1:0] stop_pt;
  wire  [`SCBC_CMD_W-1:0] clamp_pt;
  wire  [`SCBC_CMD_W-1:0] hys_band;
  wire  [`SCBC_CMD_W-1:0] chg_pt;
  wire  [`SCBC_CMD_W-1:0] cmd_in;
  wire                    chg_on;
  wire                    is_zero;
  wire                    le_stop;
  wire                    le_start;
  wire                    above_clamp;
  wire                    full_req;
  wire                    next_run;
  wire                    next_bypass;
  wire  [`SCBC_CMD_W-1:0] eval_x;
  wire  [`SCBC_CMD_W-1:0] seg1_x;
  wire  [`SCBC_CMD_W-1:0] seg2_x0;
  wire  [3:0]             shift;
  wire  [`SCBC_OUT_W-1:0] start_val;
  wire  [`SCBC_OUT_W-1:0] seg1_val;
  wire  [`SCBC_OUT_W-1:0] curve_val;
  wire  [`SCBC_OUT_W-1:0] cmd_duty;
  logic [`SCBC_OUT_W-1:0] next_target;
  logic                   next_open;

  // thresholds on the 512 scale
  assign start_pt = {2'h0, STARTUP_THRESHOLD};
  assign stop_pt  = {2'h0, STOP_THRESHOLD, 1'b0};
  assign clamp_pt = `SCBC_CLAMP_BASE + {2'h0, CLAMP_THRESHOLD};
  assign hys_band = {4'h0, ({1'b0, CLAMP_HYSTERESIS} + 5'h01), 1'b0};
  assign chg_pt   = {1'b0, CHANGE_POINT, 1'b0};
  // a change point at or below startup would never be reached on the rise
  assign chg_on   = (CHANGE_POINT != 8'h00) && (chg_pt > start_pt);

  // commands above full scale are treated as full scale
  assign cmd_in = (SPEED_COMMAND > `SCBC_CMD_FULL) ? `SCBC_CMD_FULL : SPEED_COMMAND;

  // command capture stage
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      cmd <= '0;
      upd <= 1'b0;
    end
    else
    begin
      upd <= SPEED_VALID;
      if (SPEED_VALID)
        cmd <= cmd_in;
    end
  end

  // region decode of the held command
  assign is_zero     = (cmd == '0);
  assign le_stop     = (cmd <= stop_pt);
  assign le_start    = (cmd <= start_pt);
  assign above_clamp = (cmd > clamp_pt);

  // run flag gives the hysteresis between stop and startup points
  // clearing only at the stop point keeps a falling command at startup speed
  assign next_run = !le_start ? 1'b1 : (le_stop ? 1'b0 : run);

  // bypass flag: set above clamp, cleared a band below it
  // a set bypass survives inside the band so the drive does not chatter at the clamp
  assign next_bypass = !CLAMP_OPEN_LOOP ? 1'b0 :
                       above_clamp ? 1'b1 :
                       ((cmd + hys_band) <= clamp_pt) ? 1'b0 : bypass;

  // full output requested by the zero-command option
  assign full_req = ZERO_COMMAND_FULL && (KEEP_RUNNING ? le_stop : is_zero);

  // curve scale: rpm in closed loop, 512-scale duty in open loop
  assign shift     = OPEN_LOOP_MODE ? `SCBC_SHIFT_DUTY : `SCBC_SHIFT_SPEED;
  assign start_val = OPEN_LOOP_MODE ? {10'h000, STARTUP_SPEED[11:4]}
                                    : {6'h00, STARTUP_SPEED};

  // evaluation point: clamp for the full request, else the clamped command
  // the full request evaluates the curve at the clamp, which is the maximum speed
  assign eval_x  = (full_req || above_clamp) ? clamp_pt : cmd;
  assign seg1_x  = (chg_on && (eval_x > chg_pt)) ? chg_pt : eval_x;
  assign seg2_x0 = chg_on ? chg_pt : eval_x;

  // first slope from the startup point
  scbc_slope_seg u_seg1 (
    .base  (start_val),
    .slope (SPEED_SLOPE),
    .shift (shift),
    .x     (seg1_x),
    .x0    (start_pt),
    .value (seg1_val)
  );

  // second slope continues from the change point
  // zero span below its origin makes this stage a pass-through when unused
  scbc_slope_seg u_seg2 (
    .base  (seg1_val),
    .slope (SECOND_SLOPE),
    .shift (shift),
    .x     (eval_x),
    .x0    (seg2_x0),
    .value (curve_val)
  );

  // command as a direct duty when the clamp is bypassed
  assign cmd_duty = {8'h00, cmd};

  // settings are read at the evaluation edge, so a change applies from the next command
  // output selection in priority order
  always_comb
  begin
    next_target = '0;
    next_open   = OPEN_LOOP_MODE;
    if (full_req && CLAMP_OPEN_LOOP)
    begin
      next_target = `SCBC_DUTY_FULL;
      next_open   = 1'b1;
    end
    else if (full_req)
      next_target = curve_val;
    else if (KEEP_RUNNING && le_start)
      next_target = start_val;
    else if (le_stop)
      next_target = '0;
    else if (le_start)
      next_target = next_run ? start_val : '0;
    else if (next_bypass)
    begin
      next_target = cmd_duty;
      next_open   = 1'b1;
    end
    else
      next_target = curve_val;
  end

  // result registers update once per new command
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      run    <= 1'b0;
      bypass <= 1'b0;
    end
    else if (upd)
    begin
      run    <= next_run;
      bypass <= next_bypass;
    end
  end

  // output is on whenever a non-zero speed or duty is asked for, open loop too;
  // a zero startup value just above the startup point therefore reads as off
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      TARGET       <= '0;
      TARGET_VALID <= 1'b0;
      OPEN_DRIVE   <= 1'b0;
      OUT_ENABLE   <= 1'b0;
    end
    else
    begin
      TARGET_VALID <= upd;
      if (upd)
      begin
        TARGET     <= next_target;
        OPEN_DRIVE <= next_open;
        OUT_ENABLE <= (next_target != '0);
      end
    end
  end

  // direction by command half; forward is the safe default after reset
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      DIR_FORWARD <= 1'b1;
    else if (upd)
      DIR_FORWARD <= !DIRECTION_BY_DUTY || (cmd >= `SCBC_CMD_HALF);
  end

  // rising flag is sticky: it only reports that some command ever went up
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      RISING <= 1'b0;
    else if (upd && (cmd > prev_cmd))
      RISING <= 1'b1;
  end

  // previous command kept for the rising flag
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      prev_cmd <= '0;
    else if (upd)
      prev_cmd <= cmd;
  end

  // brake decode and power-on fault source choice
  logic [1:0] brake_action;
  logic       lock_enable;
  scbc_brake_ctrl u_brake (
    .clk                 (CORE_CLK),
    .rst                 (RST),
    .brake_pin           (BRAKE_PIN),
    .brake_polarity      (BRAKE_POLARITY),
    .brake_type          (BRAKE_TYPE),
    .fault_source_select (FAULT_SOURCE_SELECT),
    .brake_action        (brake_action),
    .lock_enable         (lock_enable)
  );
  assign BRAKE_ACTION      = brake_action;
  assign FAULT_LOCK_ENABLE = lock_enable;

  // fault sources come from logic on this clock, so no synchroniser
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      FAULT <= 1'b0;
    else
      FAULT <= CHARGE_PUMP_UV || OVERCURRENT_SHUTDOWN || THERMAL_SHUTDOWN
               || (lock_enable && MOTOR_LOCK);
  end

  // checks of the curve, the fault gating and the answer timing
  AST_VALID_LATENCY: assert property (@(posedge CORE_CLK) disable iff (RST)
    SPEED_VALID |-> ##2 TARGET_VALID)
    else $error("result did not follow command by two cycles");
  AST_START_ENABLE: assert property (@(posedge CORE_CLK) disable iff (RST)
    upd && cmd > start_pt && !above_clamp && STARTUP_SPEED != 12'h000
    && !OPEN_LOOP_MODE |=> OUT_ENABLE)
    else $error("output not enabled above startup point");
  AST_STOP_ZERO: assert property (@(posedge CORE_CLK) disable iff (RST)
    upd && le_stop && !KEEP_RUNNING && !ZERO_COMMAND_FULL |=> TARGET == '0 && !OUT_ENABLE)
    else $error("target not zero at stop point");
  AST_BAND_HOLD: assert property (@(posedge CORE_CLK) disable iff (RST)
    upd && !KEEP_RUNNING && !le_stop && le_start && run
    |=> TARGET == $past(start_val))
    else $error("falling band did not hold startup value");
  AST_BAND_RISE: assert property (@(posedge CORE_CLK) disable iff (RST)
    upd && !KEEP_RUNNING && !le_stop && le_start && !run |=> TARGET == '0)
    else $error("rising band did not give zero");
  AST_CLAMP_FIXED: assert property (@(posedge CORE_CLK) disable iff (RST)
    upd && above_clamp && !CLAMP_OPEN_LOOP ##1 upd && above_clamp && !CLAMP_OPEN_LOOP
    && $stable(SPEED_SLOPE) && $stable(SECOND_SLOPE) && $stable(STARTUP_SPEED)
    && $stable(OPEN_LOOP_MODE) |=> $stable(TARGET))
    else $error("target moved above clamp");
  AST_BYPASS_DUTY: assert property (@(posedge CORE_CLK) disable iff (RST)
    upd && CLAMP_OPEN_LOOP && above_clamp |=> OPEN_DRIVE && TARGET == {8'h00, $past(cmd)})
    else $error("bypass duty does not follow command");
  AST_FULL_ZERO: assert property (@(posedge CORE_CLK) disable iff (RST)
    upd && is_zero && ZERO_COMMAND_FULL && CLAMP_OPEN_LOOP |=> TARGET == `SCBC_DUTY_FULL)
    else $error("zero command did not give full output");
  AST_DIR_HALF: assert property (@(posedge CORE_CLK) disable iff (RST)
    upd && DIRECTION_BY_DUTY |=> DIR_FORWARD == ($past(cmd) >= `SCBC_CMD_HALF))
    else $error("direction does not match command half");
  AST_KEEP_RUN: assert property (@(posedge CORE_CLK) disable iff (RST)
    upd && KEEP_RUNNING && le_start && !full_req |=> TARGET == $past(start_val))
    else $error("keep-running did not hold startup value");
  AST_CMD_FULL: assert property (@(posedge CORE_CLK) disable iff (RST)
    SPEED_VALID && SPEED_COMMAND > `SCBC_CMD_FULL |=> cmd == `SCBC_CMD_FULL)
    else $error("command above full scale not limited");
  AST_STARTUP_SPEED: assert property (@(posedge CORE_CLK) disable iff (RST)
    upd && !OPEN_LOOP_MODE && !KEEP_RUNNING && !ZERO_COMMAND_FULL && !le_stop && le_start && run
    |=> TARGET == {6'h00, $past(STARTUP_SPEED)})
    else $error("startup speed not used directly");
  AST_OPEN_STOP: assert property (@(posedge CORE_CLK) disable iff (RST)
    upd && OPEN_LOOP_MODE && le_stop && !KEEP_RUNNING && !ZERO_COMMAND_FULL
    |=> OPEN_DRIVE && !OUT_ENABLE)
    else $error("open loop output not disabled at stop point");
  AST_TARGET_HOLD: assert property (@(posedge CORE_CLK) disable iff (RST)
    !upd |=> $stable(TARGET) && $stable(OPEN_DRIVE) && $stable(OUT_ENABLE))
    else $error("result changed without a new command");
  AST_FAULT_SRC: assert property (@(posedge CORE_CLK) disable iff (RST)
    CHARGE_PUMP_UV || OVERCURRENT_SHUTDOWN || THERMAL_SHUTDOWN |=> FAULT)
    else $error("fault source did not reach the fault output");
  AST_LOCK_MASK: assert property (@(posedge CORE_CLK) disable iff (RST)
    !lock_enable && !CHARGE_PUMP_UV && !OVERCURRENT_SHUTDOWN && !THERMAL_SHUTDOWN
    |=> !FAULT)
    else $error("lock reported although not selected at power-on");

  // scenarios the bench is expected to reach
  COV_BYPASS: cover property (@(posedge CORE_CLK) disable iff (RST)
    upd && next_bypass && !above_clamp);
  COV_CHANGE: cover property (@(posedge CORE_CLK) disable iff (RST)
    upd && chg_on && cmd > chg_pt && !above_clamp);
  COV_BRAKE: cover property (@(posedge CORE_CLK) disable iff (RST)
    BRAKE_ACTION == 2'h2);
  COV_BAND_FALL: cover property (@(posedge CORE_CLK) disable iff (RST)
    upd && !le_stop && le_start && run);
  COV_OPEN_OFF: cover property (@(posedge CORE_CLK) disable iff (RST)
    upd && OPEN_LOOP_MODE && le_stop);
endmodule : scbc_top
`default_nettype wire
